// File: core/ibs_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the two-wire master
// Assumes: Included by its bare name; holds definitions only
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus
`ifndef IBS_DEFS_SVH
`define IBS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define IBS_OFF_RELOAD 8'h00
`define IBS_OFF_BUFFER 8'h04
`define IBS_OFF_CTRL1 8'h08
`define IBS_OFF_CTRL2 8'h0C
`define IBS_OFF_STATUS 8'h10
`define IBS_OFF_FLAGS 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IBS_C1_EN 5
`define IBS_C1_CKP 4
`define IBS_C2_ACKSTAT 6
`define IBS_C2_PEN 2
`define IBS_ST_SMP 7
`define IBS_ST_CKE 6
`define IBS_FL_IRQ 0
`define IBS_FL_BCL 1
`define IBS_FL_BUSY 2

// ----------------------------------------------------------------
// Mode codes, reset values, timing
// ----------------------------------------------------------------
`define IBS_MODE_I2C_MST 4'h8
`define IBS_MODE_SPI_BRG 4'hA
`define IBS_RST_BYTE 8'h00
`define IBS_BRG_PRESCALE 2'h1
`define IBS_ACK_BIT 5'h08
`define IBS_LAST_DATA_BIT 5'h07
`define IBS_SPI_LAST_HALF 5'h0F
`define IBS_RESP_OKAY 2'h0
`define IBS_RESP_SLVERR 2'h2

`endif

// File: core/ibs_pkg.sv
// Purpose: Types of the two-wire master with baud generator and status flags
// Assumes: Used with ibs_defs.svh
// Notes: All module state except the assertion counter gap_ff lives in one packed struct
package ibs_pkg;

	// ----------------------------------------------------------------
	// Sequencer states, Gray coded along the Stop path from ST_IDLE to ST_STP_FIN
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_STP_DLO = 4'h1,
		ST_STP_BRG1 = 4'h3,
		ST_STP_SCLH = 4'h2,
		ST_STP_BRG2 = 4'h6,
		ST_STP_BRG3 = 4'h7,
		ST_STP_FIN = 4'h5,
		ST_TX_LO = 4'h8,
		ST_TX_HI = 4'h9,
		ST_TX_CNT = 4'hB,
		ST_SPI_RUN = 4'hC
	} ibs_st_t;

	// ----------------------------------------------------------------
	// Whole state of the block except the assertion counter gap_ff
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_hold;
		logic [7:0] aw_addr;
		logic w_hold;
		logic [7:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] reload;
		logic en;
		logic ckp;
		logic [3:0] mode;
		logic stop_enable;
		logic ackstat;
		logic input_sample_select;
		logic cke;
		logic data_addr;
		logic stop_seen;
		logic start_seen;
		logic rw;
		logic buffer_full_flag;
		logic serial_port_irq_flag;
		logic bus_collision_flag;
		logic addr_next;
		logic [7:0] rxb;
		logic [7:0] rxsh;
		logic [7:0] shreg;
		logic [4:0] cnt;
		ibs_st_t st;
		logic [7:0] brg_cnt;
		logic [1:0] pre;
		logic brg_run;
		logic [2:0] sda_s;
		logic [2:0] scl_s;
		logic [2:0] sdi_s;
		logic sda_f;
		logic scl_f;
		logic sdi_f;
		logic sda_prev;
		logic scl_oe;
		logic sda_oe;
		logic sck;
		logic sdo;
		logic slew_en;
		logic smbus_th;
	} ibs_state_t;

endpackage

// File: core/ibs_top.sv
// Purpose: Two-wire / serial-peripheral master with baud generator, Stop and status flags
// Assumes: aclk is the oscillator; AXI4-Lite register access; open-drain pins resolved outside
// Notes: Slave addressing and Start/Ack sequencing live elsewhere
//
// Notes on behaviour
// RQ1: In Stop, data sampled low after release and generator expiry flags a collision.
// RQ2: In Stop, clock sampled low before data goes high flags a collision.
// RQ3: Stop drives data low, releases clock, counts a generator period, then samples data.
// RQ4: Generator makes the serial clock in two-wire and serial-peripheral master modes.
// RQ5: Writing the shift buffer starts the generator counting.
// RQ6: After an operation the generator stops and the clock keeps its last level.
// RQ7: Reload strobe copies the reload value twice per serial clock period.
// RQ8: Serial clock equals oscillator over four times reload plus one.
// RQ9: Software avoids reload values 0x00, 0x01, 0x02 for the two-wire bus.
// RQ10: Peripheral master samples input at end when bit 7 set, middle otherwise.
// RQ11: Software keeps the sample select bit clear in peripheral slave use.
// RQ12: In two-wire mode bit 7 set disables slew control, clear enables it.
// RQ13: Peripheral mode bit 6 selects active-to-idle or idle-to-active data change.
// RQ14: In two-wire mode the clock-edge bit selects SMBus input thresholds.
// RQ15: Bit 5 reads 1 after a data byte, 0 after an address byte.
// RQ16: Bit 4 set when Stop detected last; cleared at reset and disable.
// RQ17: Bit 3 set when Start detected last; cleared at reset and disable.
// RQ18: Slave direction bit holds the last matching address direction. Here the bit shows the master direction rw; no slave matching.
// RQ19: Master direction bit shows transmit; ORed with enables it shows busy.
// RQ20: Bit 1 flags that software must reload the next address part. Here bit 1 always reads 0.
// RQ21: Buffer-full set when a received byte completes, clear when the buffer empties.
// RQ22: On two-wire transmit buffer-full stays set until the data bits are sent.
// RQ23: Any collision sets the collision flag and returns the port to idle.
// RQ24: After Stop, set stop status, one generator period later clear enable, flag.
// RQ25: Generator decrements once per instruction cycle and rolls over at zero.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "ibs_defs.svh"

module ibs_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic sck_o,
	output logic sdo_o,
	input wire logic sdi_i,
	output logic slew_ctrl_en,
	output logic smbus_thresholds
);
	import ibs_pkg::*;

	localparam ibs_state_t RST_S = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
		st: ST_IDLE, sda_s: 3'h7, scl_s: 3'h7, sda_f: 1'b1, scl_f: 1'b1, sda_prev: 1'b1,
		slew_en: 1'b1, default: '0};

	ibs_state_t s_ff;
	ibs_state_t nxt_s;
	logic roll;
	logic brg_load;
	logic coll;
	logic i2c_mst;
	logic spi_mst;
	logic lead;
	logic chg;
	logic [7:0] rbyte;
	logic [10:0] gap_ff;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		brg_load = 1'b0;
		coll = 1'b0;
		rbyte = `IBS_RST_BYTE;
		lead = 1'b0;
		chg = 1'b0;
		i2c_mst = s_ff.en && (s_ff.mode == `IBS_MODE_I2C_MST);
		spi_mst = s_ff.en && (s_ff.mode == `IBS_MODE_SPI_BRG);
		roll = s_ff.brg_run && (s_ff.pre == `IBS_BRG_PRESCALE) && (s_ff.brg_cnt == 8'h00);

		// Pin synchronisers; a change counts once stages two and three agree
		nxt_s.sda_s = {s_ff.sda_s[1:0], sda_i};
		nxt_s.scl_s = {s_ff.scl_s[1:0], scl_i};
		nxt_s.sdi_s = {s_ff.sdi_s[1:0], sdi_i};
		if (s_ff.sda_s[1] == s_ff.sda_s[2]) begin
			nxt_s.sda_f = s_ff.sda_s[2];
		end
		if (s_ff.scl_s[1] == s_ff.scl_s[2]) begin
			nxt_s.scl_f = s_ff.scl_s[2];
		end
		if (s_ff.sdi_s[1] == s_ff.sdi_s[2]) begin
			nxt_s.sdi_f = s_ff.sdi_s[2];
		end
		nxt_s.sda_prev = s_ff.sda_f;

		// Generator: one decrement per two oscillator cycles, reload on rollover
		if (s_ff.brg_run) begin
			nxt_s.pre = (s_ff.pre == `IBS_BRG_PRESCALE) ? 2'h0 : s_ff.pre + 2'h1; // RQ8 RQ25
			if (s_ff.pre == `IBS_BRG_PRESCALE) begin
				if (s_ff.brg_cnt == 8'h00) begin
					nxt_s.brg_cnt = s_ff.reload; // RQ7
				end else begin
					nxt_s.brg_cnt = s_ff.brg_cnt - 8'h01; // RQ25
				end
			end
		end

		// Bus monitor for Start and Stop conditions
		if (s_ff.scl_f && s_ff.sda_prev && !s_ff.sda_f) begin
			nxt_s.start_seen = 1'b1; // RQ17
			nxt_s.stop_seen = 1'b0;
			nxt_s.addr_next = 1'b1;
		end
		if (s_ff.scl_f && !s_ff.sda_prev && s_ff.sda_f) begin
			nxt_s.stop_seen = 1'b1; // RQ16
			nxt_s.start_seen = 1'b0;
		end

		// AXI read channel; reading the buffer empties it
		if (s_ff.rvalid && rready) begin
			nxt_s.rvalid = 1'b0;
			nxt_s.arready = 1'b1;
		end
		if (arvalid && s_ff.arready) begin
			nxt_s.arready = 1'b0;
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = `IBS_RESP_OKAY;
			case (araddr)
				`IBS_OFF_RELOAD: rbyte = s_ff.reload;
				`IBS_OFF_BUFFER: begin
					rbyte = s_ff.rxb;
					nxt_s.buffer_full_flag = 1'b0; // RQ21
				end
				`IBS_OFF_CTRL1: rbyte = {2'h0, s_ff.en, s_ff.ckp, s_ff.mode};
				`IBS_OFF_CTRL2: rbyte = {1'b0, s_ff.ackstat, 3'h0, s_ff.stop_enable, 2'h0};
				// Direction bit shows the master rw and address update stays clear: no slave matching here
				`IBS_OFF_STATUS: rbyte = {s_ff.input_sample_select, s_ff.cke, s_ff.data_addr,
					s_ff.stop_seen, s_ff.start_seen, s_ff.rw, 1'b0, s_ff.buffer_full_flag}; // RQ18 RQ20
				`IBS_OFF_FLAGS: rbyte = {5'h00, s_ff.rw | s_ff.stop_enable,
					s_ff.bus_collision_flag, s_ff.serial_port_irq_flag}; // RQ19
				default: nxt_s.rresp = `IBS_RESP_SLVERR;
			endcase
			nxt_s.rdata = {24'h00_0000, rbyte};
		end

		// AXI write channel; address and data taken in either order
		if (s_ff.bvalid && bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (awvalid && s_ff.awready) begin
			nxt_s.aw_hold = 1'b1;
			nxt_s.aw_addr = awaddr;
		end
		if (wvalid && s_ff.wready) begin
			nxt_s.w_hold = 1'b1;
			nxt_s.w_data = wdata[7:0];
			nxt_s.w_lane0 = wstrb[0];
		end
		if (s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid) begin
			nxt_s.aw_hold = 1'b0;
			nxt_s.w_hold = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = `IBS_RESP_OKAY;
			case (s_ff.aw_addr)
				`IBS_OFF_RELOAD: begin
					if (s_ff.w_lane0) begin
						nxt_s.reload = s_ff.w_data;
					end
				end
				`IBS_OFF_BUFFER: begin
					// Writes while a sequence runs are dropped
					if (s_ff.w_lane0 && s_ff.st == ST_IDLE && !s_ff.stop_enable) begin
						if (i2c_mst) begin
							nxt_s.shreg = s_ff.w_data;
							nxt_s.sda_oe = !s_ff.w_data[7];
							nxt_s.scl_oe = 1'b1;
							nxt_s.cnt = 5'h00;
							nxt_s.buffer_full_flag = 1'b1; // RQ22
							nxt_s.rw = 1'b1; // RQ19
							nxt_s.st = ST_TX_LO;
							brg_load = 1'b1; // RQ5
						end else if (spi_mst) begin
							nxt_s.shreg = s_ff.w_data;
							nxt_s.sdo = s_ff.w_data[7];
							nxt_s.sck = s_ff.ckp;
							nxt_s.cnt = 5'h00;
							nxt_s.st = ST_SPI_RUN;
							brg_load = 1'b1; // RQ5
						end
					end
				end
				`IBS_OFF_CTRL1: begin
					if (s_ff.w_lane0) begin
						nxt_s.en = s_ff.w_data[`IBS_C1_EN];
						nxt_s.ckp = s_ff.w_data[`IBS_C1_CKP];
						nxt_s.mode = s_ff.w_data[3:0];
					end
				end
				`IBS_OFF_CTRL2: begin
					// Stop may only be requested while the port is idle
					if (s_ff.w_lane0 && s_ff.w_data[`IBS_C2_PEN] && i2c_mst &&
						s_ff.st == ST_IDLE && !s_ff.stop_enable) begin
						nxt_s.stop_enable = 1'b1;
						nxt_s.st = ST_STP_DLO;
					end
				end
				`IBS_OFF_STATUS: begin
					if (s_ff.w_lane0) begin
						nxt_s.input_sample_select = s_ff.w_data[`IBS_ST_SMP];
						nxt_s.cke = s_ff.w_data[`IBS_ST_CKE];
					end
				end
				`IBS_OFF_FLAGS: begin
					// Write one to clear; hardware sets below win
					if (s_ff.w_lane0) begin
						nxt_s.serial_port_irq_flag = s_ff.serial_port_irq_flag &
							!s_ff.w_data[`IBS_FL_IRQ];
						nxt_s.bus_collision_flag = s_ff.bus_collision_flag &
							!s_ff.w_data[`IBS_FL_BCL];
					end
				end
				default: nxt_s.bresp = `IBS_RESP_SLVERR;
			endcase
		end
		nxt_s.awready = !nxt_s.aw_hold;
		nxt_s.wready = !nxt_s.w_hold;

		// Sequencer
		case (s_ff.st)
			ST_IDLE: nxt_s.brg_run = 1'b0; // RQ6
			ST_STP_DLO: begin
				nxt_s.sda_oe = 1'b1; // RQ3
				nxt_s.scl_oe = 1'b1;
				if (!s_ff.sda_f) begin
					brg_load = 1'b1;
					nxt_s.st = ST_STP_BRG1;
				end
			end
			ST_STP_BRG1: begin
				if (roll) begin
					nxt_s.scl_oe = 1'b0; // RQ3
					nxt_s.st = ST_STP_SCLH;
				end
			end
			ST_STP_SCLH: begin
				// Clock arbitration: wait for the line to rise
				if (s_ff.scl_f) begin
					brg_load = 1'b1; // RQ3
					nxt_s.st = ST_STP_BRG2;
				end
			end
			ST_STP_BRG2: begin
				if (!s_ff.scl_f) begin
					coll = 1'b1; // RQ2
				end else if (roll) begin
					nxt_s.sda_oe = 1'b0;
					nxt_s.st = ST_STP_BRG3;
				end
			end
			ST_STP_BRG3: begin
				if (!s_ff.scl_f && !s_ff.sda_f) begin
					coll = 1'b1; // RQ2
				end else if (roll) begin
					if (!s_ff.sda_f) begin
						coll = 1'b1; // RQ1
					end else begin
						nxt_s.stop_seen = 1'b1; // RQ24
						nxt_s.start_seen = 1'b0;
						nxt_s.st = ST_STP_FIN;
					end
				end
			end
			ST_STP_FIN: begin
				if (roll) begin
					nxt_s.stop_enable = 1'b0; // RQ24
					nxt_s.serial_port_irq_flag = 1'b1;
					nxt_s.st = ST_IDLE;
				end
			end
			ST_TX_LO: begin
				if (roll) begin
					nxt_s.scl_oe = 1'b0; // RQ4
					nxt_s.st = ST_TX_HI;
				end
			end
			ST_TX_HI: begin
				if (s_ff.scl_f) begin
					brg_load = 1'b1;
					nxt_s.st = ST_TX_CNT;
				end
			end
			ST_TX_CNT: begin
				// Released data bit pulled low by another master
				if (s_ff.cnt != `IBS_ACK_BIT && s_ff.shreg[7] && !s_ff.sda_f) begin
					coll = 1'b1; // RQ23
				end else if (roll) begin
					nxt_s.scl_oe = 1'b1;
					if (s_ff.cnt == `IBS_ACK_BIT) begin
						nxt_s.ackstat = s_ff.sda_f;
						nxt_s.serial_port_irq_flag = 1'b1;
						nxt_s.rw = 1'b0; // RQ19
						nxt_s.st = ST_IDLE;
					end else begin
						if (s_ff.cnt == `IBS_LAST_DATA_BIT) begin
							nxt_s.buffer_full_flag = 1'b0; // RQ22
							nxt_s.data_addr = !s_ff.addr_next; // RQ15
							nxt_s.addr_next = 1'b0;
						end
						nxt_s.shreg = {s_ff.shreg[6:0], 1'b1};
						nxt_s.sda_oe = !s_ff.shreg[6];
						nxt_s.cnt = s_ff.cnt + 5'h01;
						nxt_s.st = ST_TX_LO;
					end
				end
			end
			ST_SPI_RUN: begin
				if (roll) begin
					nxt_s.sck = !s_ff.sck; // RQ4
					lead = !s_ff.cnt[0];
					if (lead == (s_ff.cke ^ s_ff.input_sample_select)) begin
						nxt_s.rxsh = {s_ff.rxsh[6:0], s_ff.sdi_f}; // RQ10
					end
					chg = (lead == !s_ff.cke) && !(!s_ff.cke && s_ff.cnt == 5'h00) &&
						!(s_ff.cke && s_ff.cnt == `IBS_SPI_LAST_HALF); // RQ13
					if (chg) begin
						nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
						nxt_s.sdo = s_ff.shreg[6];
					end
					nxt_s.cnt = s_ff.cnt + 5'h01;
					if (s_ff.cnt == `IBS_SPI_LAST_HALF) begin
						nxt_s.rxb = nxt_s.rxsh;
						nxt_s.buffer_full_flag = 1'b1; // RQ21
						nxt_s.serial_port_irq_flag = 1'b1;
						nxt_s.st = ST_IDLE;
					end
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase

		// Reload strobe from a buffer write or the sequencer restarts the half period
		if (brg_load) begin
			nxt_s.brg_cnt = s_ff.reload; // RQ7
			nxt_s.pre = 2'h0;
			nxt_s.brg_run = 1'b1; // RQ5
		end

		// Collision aborts the sequence and frees both lines
		if (coll) begin
			nxt_s.bus_collision_flag = 1'b1; // RQ23
			nxt_s.st = ST_IDLE;
			nxt_s.sda_oe = 1'b0;
			nxt_s.scl_oe = 1'b0;
			nxt_s.stop_enable = 1'b0;
			nxt_s.buffer_full_flag = 1'b0;
			nxt_s.rw = 1'b0;
			nxt_s.brg_run = 1'b0;
		end

		// Disabled port: idle, lines free, Start/Stop history cleared
		if (!s_ff.en) begin
			nxt_s.st = ST_IDLE;
			nxt_s.sda_oe = 1'b0;
			nxt_s.scl_oe = 1'b0;
			nxt_s.stop_enable = 1'b0;
			nxt_s.rw = 1'b0;
			nxt_s.brg_run = 1'b0;
			nxt_s.stop_seen = 1'b0; // RQ16
			nxt_s.start_seen = 1'b0; // RQ17
		end

		// Pad controls follow the two-wire option bits
		nxt_s.slew_en = !s_ff.input_sample_select; // RQ12
		nxt_s.smbus_th = s_ff.cke && i2c_mst; // RQ14
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= RST_S;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Ports straight from the state register; scl_o and sda_o tied low
	assign awready = s_ff.awready;
	assign wready = s_ff.wready;
	assign bvalid = s_ff.bvalid;
	assign bresp = s_ff.bresp;
	assign arready = s_ff.arready;
	assign rvalid = s_ff.rvalid;
	assign rdata = s_ff.rdata;
	assign rresp = s_ff.rresp;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = s_ff.scl_oe;
	assign sda_oe = s_ff.sda_oe;
	assign sck_o = s_ff.sck;
	assign sdo_o = s_ff.sdo;
	assign slew_ctrl_en = s_ff.slew_en;
	assign smbus_thresholds = s_ff.smbus_th;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Cycles since the last reload of the generator
	always_ff @(posedge aclk) begin
		if (!aresetn || brg_load || roll) begin
			gap_ff <= 11'h001;
		end else if (gap_ff != 11'h7FF) begin
			gap_ff <= gap_ff + 11'h001;
		end
	end

	AST_BRG_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
		roll && $stable(s_ff.reload) |-> gap_ff == ({3'h0, s_ff.reload} + 11'h001) * 11'h002)
		else $error("generator half period wrong");
	AST_RELOAD_COPY: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
		roll && s_ff.st != ST_IDLE && s_ff.en && !coll |=> s_ff.brg_cnt == $past(s_ff.reload))
		else $error("reload not copied on rollover");
	AST_STOP_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
		s_ff.st == ST_STP_BRG1 |-> s_ff.sda_oe && s_ff.scl_oe)
		else $error("stop lines not held low");
	AST_STOP_SDA_COLL: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
		s_ff.en && s_ff.st == ST_STP_BRG3 && roll && !s_ff.sda_f
		|=> s_ff.bus_collision_flag && s_ff.st == ST_IDLE && !s_ff.stop_enable)
		else $error("data low after stop not flagged");
	AST_STOP_SCL_COLL: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
		s_ff.en && s_ff.st == ST_STP_BRG2 && !s_ff.scl_f
		|=> s_ff.bus_collision_flag && !s_ff.scl_oe && !s_ff.sda_oe)
		else $error("clock low during stop not flagged");
	AST_START_COUNT: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
		s_ff.st == ST_IDLE && s_ff.en && $changed(s_ff.st) == 1'b0 ##1 s_ff.st == ST_TX_LO
		|-> s_ff.brg_run && s_ff.brg_cnt == s_ff.reload && s_ff.buffer_full_flag)
		else $error("buffer write did not start generator");
	AST_IDLE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
		s_ff.st == ST_IDLE && $past(s_ff.st) == ST_IDLE |-> $stable(s_ff.sck) && !s_ff.brg_run)
		else $error("clock moved while idle");
	AST_STOP_FINISH: assert property (@(posedge aclk) disable iff (!aresetn) // RQ24
		s_ff.en && s_ff.st == ST_STP_FIN && roll
		|=> !s_ff.stop_enable && s_ff.serial_port_irq_flag && s_ff.stop_seen)
		else $error("stop completion wrong");
	AST_DISABLE_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16 RQ17
		!s_ff.en |=> !s_ff.stop_seen && !s_ff.start_seen)
		else $error("start or stop flag kept while disabled");

endmodule // ibs_top

// File: test/ibs_bus_peer.sv
// Purpose: Bus peer on the two-wire lines: pull-ups, byte capture, acknowledge
// Assumes: Released lines float high through pull-ups
// Notes: The bench may hold either line low to play a competing master
`timescale 1ns/10ps
module ibs_bus_peer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic scl_lo,
	input wire logic sda_lo,
	input wire logic ack_en,
	output logic scl,
	output logic sda,
	output logic [7:0] rx_byte
);
	logic scl_q;
	logic ack_drv;
	logic [3:0] n;

	// Wired-AND lines, high when nobody pulls
	assign scl = ~(scl_oe | scl_lo);
	assign sda = ~(sda_oe | sda_lo | ack_drv);

	// Shift in eight bits on rising clock, hold data low across the ninth
	always_ff @(posedge aclk) begin
		scl_q <= scl;
		if (!aresetn) begin
			n <= 4'h0;
			ack_drv <= 1'b0;
			rx_byte <= 8'h00;
			scl_q <= 1'b1;
		end else if (scl && !scl_q && n < 4'h9) begin
			if (n < 4'h8) rx_byte <= {rx_byte[6:0], sda};
			n <= n + 4'h1;
		end else if (!scl && scl_q) begin
			if (n == 4'h8) ack_drv <= ack_en;
			if (n == 4'h9) ack_drv <= 1'b0;
		end
	end
endmodule // ibs_bus_peer

// File: test/tb_top.sv
// Purpose: Self-checking bench of the two-wire master, generator and status
// Assumes: Register access over AXI4-Lite; peer model on the lines
// Notes: Random values from an xorshift seeded with 26
`timescale 1ns/10ps
`include "ibs_defs.svh"
module tb_top;
	import ibs_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sdi_i;
	logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, sck_o, slew, smb;
	logic scl, sda, scl_lo, sda_lo, ack_en, b, sdo;
	logic [7:0] awaddr, araddr, r, d, rx_byte;
	logic [31:0] wdata, rdata, rs, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int errors, check_count, k, j, n;

	// ----------------------------------------------------------------
	// Clock, design and peer
	// ----------------------------------------------------------------
	always #20 aclk = ~aclk;

	ibs_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.sck_o(sck_o), .sdo_o(sdo), .sdi_i(sdi_i), .slew_ctrl_en(slew), .smbus_thresholds(smb));

	ibs_bus_peer i_peer (.aclk(aclk), .aresetn(aresetn), .scl_oe(scl_oe), .sda_oe(sda_oe),
		.scl_lo(scl_lo), .sda_lo(sda_lo), .ack_en(ack_en), .scl(scl), .sda(sda),
		.rx_byte(rx_byte));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function logic [31:0] nxt_rand();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// Generator half period in clocks
	function int half_per(input logic [7:0] rl);
		return 2 * (int'(rl) + 1);
	endfunction

	task test_done();
		if (errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task tmo();
		chk("timeout", 32'h0000_0000, 32'h0000_0001);
		test_done();
	endtask

	// Write one byte; upper data bits are random and ignored
	task axw(input logic [7:0] a, input logic [7:0] dd);
		bit aw, w;
		v = nxt_rand();
		awaddr <= a;
		wdata <= {v[31:8], dd};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw = 0;
		w = 0;
		for (k = 0; !(aw && w); k++) begin
			if (k > 100) tmo();
			@(posedge aclk);
			if (awvalid && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (bvalid) break;
		end
		if (k == 100) tmo();
		chk("bresp", `IBS_RESP_OKAY, bresp);
		bready <= 1'b0;
	endtask

	task axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] q);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (k == 100) tmo();
		q = rdata;
		chk("rresp", er, rresp);
		rready <= 1'b0;
		// One edge apart, so a following read never re-drives rready in this step
		@(posedge aclk);
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		axr(a, `IBS_RESP_OKAY, v);
		chk(nm, {24'h0, e}, v & {24'h0, m});
	endtask

	task poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		for (j = 0; j < 500; j++) begin
			axr(a, `IBS_RESP_OKAY, v);
			if ((v[7:0] & m) == e) break;
		end
		if (j == 500) tmo();
	endtask

	// Clocks until the serial clock changes, seen at falling edges
	task wait_chg(output int cnt);
		logic s;
		s = sck_o;
		for (cnt = 0; cnt < 300 && sck_o === s; cnt++) @(negedge aclk);
		if (cnt == 300) tmo();
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sdi_i} = 8'h00;
		{scl_lo, sda_lo, ack_en, awaddr, araddr, wdata} = 0;
		wstrb = 4'hF;
		rs = 32'h0000_001A;
		errors = 0;
		check_count = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values and an unmapped read
		rdc("status rst", `IBS_OFF_STATUS, 8'hFF, 8'h00);
		rdc("flags rst", `IBS_OFF_FLAGS, 8'hFF, 8'h00);
		axr(8'h18, `IBS_RESP_SLVERR, v);
		chk("unmapped", 32'h0000_0000, v);
		chk("slew rst", 32'h0000_0001, {31'h0, slew});
		chk("smbus rst", 32'h0000_0000, {31'h0, smb});
		// Reload kept at 3 or above for the two-wire bus
		r = 8'h03 + {6'h0, nxt_rand() & 32'h0000_0003};
		axw(`IBS_OFF_RELOAD, r);
		rdc("reload", `IBS_OFF_RELOAD, 8'hFF, r);
		axw(`IBS_OFF_CTRL1, 8'h28);
		axw(`IBS_OFF_STATUS, 8'hC0);
		// Pad controls follow the register one clock later
		@(posedge aclk);
		chk("slew off", 32'h0000_0000, {31'h0, slew});
		chk("smbus on", 32'h0000_0001, {31'h0, smb});
		axw(`IBS_OFF_STATUS, 8'h00);
		@(posedge aclk);
		chk("slew on", 32'h0000_0001, {31'h0, slew});
		// Transmit a random byte, peer acknowledges
		ack_en <= 1'b1;
		d = nxt_rand() & 32'h0000_00FF;
		axw(`IBS_OFF_BUFFER, d);
		rdc("tx busy", `IBS_OFF_STATUS, 8'h05, 8'h05);
		poll(`IBS_OFF_FLAGS, 8'h01, 8'h01);
		chk("tx byte", {24'h0, d}, {24'h0, rx_byte});
		rdc("tx done", `IBS_OFF_STATUS, 8'h25, 8'h20);
		rdc("ack", `IBS_OFF_CTRL2, 8'h40, 8'h00);
		axw(`IBS_OFF_FLAGS, 8'h01);
		// Normal Stop
		axw(`IBS_OFF_CTRL2, 8'h04);
		poll(`IBS_OFF_FLAGS, 8'h04, 8'h00);
		rdc("stop seen", `IBS_OFF_STATUS, 8'h10, 8'h10);
		rdc("stop flags", `IBS_OFF_FLAGS, 8'h07, 8'h01);
		chk("lines idle", 32'h0000_0003, {30'h0, scl, sda});
		axw(`IBS_OFF_FLAGS, 8'h01);
		// Stop with data held low by another master
		sda_lo <= 1'b1;
		axw(`IBS_OFF_CTRL2, 8'h04);
		poll(`IBS_OFF_FLAGS, 8'h04, 8'h00);
		rdc("bcl data", `IBS_OFF_FLAGS, 8'h03, 8'h02);
		chk("released", 32'h0000_0000, {30'h0, sda_oe, scl_oe});
		sda_lo <= 1'b0;
		axw(`IBS_OFF_FLAGS, 8'h02);
		// Stop with the clock pulled low before data rises
		axw(`IBS_OFF_CTRL2, 8'h04);
		// The sequence first pulls the clock, then releases it
		for (k = 0; k < 300 && scl_oe !== 1'b1; k++) @(negedge aclk);
		if (k == 300) tmo();
		for (k = 0; k < 300 && scl_oe !== 1'b0; k++) @(negedge aclk);
		if (k == 300) tmo();
		repeat (6) @(posedge aclk);
		scl_lo <= 1'b1;
		poll(`IBS_OFF_FLAGS, 8'h04, 8'h00);
		rdc("bcl clock", `IBS_OFF_FLAGS, 8'h03, 8'h02);
		scl_lo <= 1'b0;
		axw(`IBS_OFF_FLAGS, 8'h02);
		// Disabling clears Start and Stop status; the released data line left a Stop
		rdc("stop kept", `IBS_OFF_STATUS, 8'h10, 8'h10);
		axw(`IBS_OFF_CTRL1, 8'h08);
		rdc("disabled", `IBS_OFF_STATUS, 8'h18, 8'h00);
		// Peripheral master: clock rate and reception
		v = nxt_rand();
		b = v[8];
		r = 8'h03 + {6'h0, v[1:0]};
		sdi_i <= b;
		axw(`IBS_OFF_RELOAD, r);
		axw(`IBS_OFF_CTRL1, 8'h2A);
		d = v[23:16];
		axw(`IBS_OFF_BUFFER, d);
		chk("sdo first", {31'h0, d[7]}, {31'h0, sdo});
		wait_chg(n);
		wait_chg(n);
		chk("half period", half_per(r), n);
		poll(`IBS_OFF_FLAGS, 8'h01, 8'h01);
		repeat (8) @(posedge aclk);
		chk("sck idle", 32'h0000_0000, {31'h0, sck_o});
		rdc("rx full", `IBS_OFF_STATUS, 8'h01, 8'h01);
		rdc("rx byte", `IBS_OFF_BUFFER, 8'hFF, {8{b}});
		rdc("rx empty", `IBS_OFF_STATUS, 8'h01, 8'h00);
		test_done();
	end
endmodule // tb_top
